/* core/pfgm_pin_sel.sv */
`timescale 1ns/1ns
// One pin's override resolution
module pfgm_pin_sel (
  input  wire logic pu_reg_i,
  input  wire logic dir_reg_i,
  input  wire logic val_reg_i,
  input  wire logic pu_oe_i,
  input  wire logic pu_ov_i,
  input  wire logic dir_oe_i,
  input  wire logic dir_ov_i,
  input  wire logic val_oe_i,
  input  wire logic val_ov_i,
  input  wire logic die_oe_i,
  input  wire logic die_ov_i,
  output wire logic pu_o,
  output wire logic dir_o,
  output wire logic val_o,
  output wire logic die_o
);
  // Each enable swaps the register bit (a fixed 1 for the input enable) for its override value
  assign pu_o  = pu_oe_i  ? pu_ov_i  : pu_reg_i;
  assign dir_o = dir_oe_i ? dir_ov_i : dir_reg_i;
  assign val_o = val_oe_i ? val_ov_i : val_reg_i;
  assign die_o = die_oe_i ? die_ov_i : 1'b1;
endmodule

/* core/pfgm_pkg.sv */
// Contract
// - Scan port enable forces pull-up override on, value 1, for upper four.
// - Scan enable owns upper direction; data-out drives only while shifting.
// - Scan enable replaces data-out pin value with scan test data-out.
// - Scan enable forces digital input off on upper four pins.
// - Lower four analog pins have every override held at zero.
// - LCD on and mask above 5 override segment pin 4, direction 1.
// - Segment pin 4 toggle override is 1; its input feeds timer zero.
// - Segment pin 4 analog side carries front plane twenty three.
// - LCD on and mask above 6 override pin 3; else timer one input.
// - Segment pin 2 overridden whenever LCD on, all values zero.
// - Segment pins 1 and 0 overridden when LCD on and mask above 0.
// - Port A data and direction registers are 8 bits, RW, reset zero.
package pfgm_pkg;
  localparam logic [11:0] PFGM_OFS_PORT_A_DATA = 12'h000;
  localparam logic [11:0] PFGM_OFS_PORT_A_DIR  = 12'h004;
  localparam logic [11:0] PFGM_OFS_SEG_CTRL    = 12'h008;
  localparam logic [11:0] PFGM_OFS_PIN_STATUS  = 12'h00c;
  localparam logic [7:0]  PFGM_RST_PORT_A      = 8'h00;
  localparam logic [3:0]  PFGM_RST_SEG_CTRL    = 4'h0;
  localparam int          PFGM_BIT_LCD_EN      = 0;
  localparam int          PFGM_POS_PORT_MASK   = 1;
  localparam logic [2:0]  PFGM_MASK_PIN4       = 3'h5;
  localparam logic [2:0]  PFGM_MASK_PIN3       = 3'h6;
  localparam logic [2:0]  PFGM_MASK_PIN10      = 3'h0;
endpackage

/* core/pfgm_top.sv */
`timescale 1ns/1ns
// Port F/G override mux with port A registers on APB
module pfgm_top (
  input  wire logic        ref_clk_i,
  input  wire logic        sys_rst_i,
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [11:0] paddr_i,
  input  wire logic [31:0] pwdata_i,
  output logic      [31:0] prdata_o,
  output logic             pready_o,
  output logic             pslverr_o,
  input  wire logic        scan_port_enable_i,
  input  wire logic        tap_shifting_instruction_i,
  input  wire logic        tap_shifting_data_i,
  input  wire logic        scan_data_out_i,
  input  wire logic [7:0]  port_f_reg_i,
  input  wire logic [7:0]  port_f_dir_i,
  input  wire logic [7:0]  port_f_pu_i,
  input  wire logic [4:0]  port_g_reg_i,
  input  wire logic [4:0]  port_g_dir_i,
  input  wire logic [4:0]  port_g_pu_i,
  input  wire logic [4:0]  port_g_pin_i,
  output logic [7:0]       port_a_out_o,
  output logic [7:0]       port_a_oe_o,
  output logic [7:0]       port_f_pu_o,
  output logic [7:0]       port_f_oe_o,
  output logic [7:0]       port_f_out_o,
  output logic [7:0]       port_f_die_o,
  output logic [7:0]       port_f_analog_o,
  output logic [4:0]       port_g_pu_o,
  output logic [4:0]       port_g_oe_o,
  output logic [4:0]       port_g_out_o,
  output logic [4:0]       port_g_die_o,
  output logic             port_g4_toggle_oe_o,
  output logic             timer_zero_clock_in_o,
  output logic             timer_one_clock_in_o,
  output logic [4:0]       lcd_front_plane_o
);
  import pfgm_pkg::*;

  logic [7:0] port_a_output_data_ff;
  logic [7:0] port_a_direction_ff;
  logic       lcd_en_ff;
  logic [2:0] port_mask_ff;
  logic [4:0] g_pin_s1_ff;
  logic [4:0] g_pin_s2_ff;

  // APB decode; zero wait states, unmapped reads zero with error
  wire        acc   = psel_i & penable_i;
  wire        wr    = acc & pwrite_i;
  wire        hit_d = paddr_i == PFGM_OFS_PORT_A_DATA;
  wire        hit_r = paddr_i == PFGM_OFS_PORT_A_DIR;
  wire        hit_c = paddr_i == PFGM_OFS_SEG_CTRL;
  wire        hit_s = paddr_i == PFGM_OFS_PIN_STATUS;
  wire        hit   = hit_d | hit_r | hit_c | hit_s;
  wire        segment_driver_enable = lcd_en_ff;
  wire [2:0]  segment_port_mask     = port_mask_ff;
  wire [31:0] rd_mux =
      hit_d ? {24'h000000, port_a_output_data_ff} :
      hit_r ? {24'h000000, port_a_direction_ff} :
      hit_c ? {28'h0000000, port_mask_ff, lcd_en_ff} :
      hit_s ? {27'h0000000, g_pin_s2_ff} : 32'h00000000;

  // Register writes land only at the access edge
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      port_a_output_data_ff <= PFGM_RST_PORT_A;
      port_a_direction_ff   <= PFGM_RST_PORT_A;
      lcd_en_ff             <= PFGM_RST_SEG_CTRL[0];
      port_mask_ff          <= PFGM_RST_SEG_CTRL[3:1];
    end else if (wr) begin
      if (hit_d) port_a_output_data_ff <= pwdata_i[7:0];
      if (hit_r) port_a_direction_ff   <= pwdata_i[7:0];
      if (hit_c) begin
        lcd_en_ff    <= pwdata_i[PFGM_BIT_LCD_EN];
        port_mask_ff <= pwdata_i[PFGM_POS_PORT_MASK +: 3];
      end
    end
  end

  // Bus answer registered; pready held high so every access is one cycle
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      prdata_o  <= 32'h00000000;
      pready_o  <= 1'b1;
      pslverr_o <= 1'b0;
    end else begin
      prdata_o  <= (psel_i & ~penable_i) ? rd_mux : prdata_o;
      pready_o  <= 1'b1;
      pslverr_o <= psel_i & ~penable_i & ~hit;
    end
  end

  // Pad inputs are asynchronous, two stages before use
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      g_pin_s1_ff <= 5'h00;
      g_pin_s2_ff <= 5'h00;
    end else begin
      g_pin_s1_ff <= port_g_pin_i;
      g_pin_s2_ff <= g_pin_s1_ff;
    end
  end

  // Override terms per pin
  wire       shifting = tap_shifting_instruction_i | tap_shifting_data_i;
  wire       g4_ov  = segment_driver_enable &
                      (segment_port_mask > PFGM_MASK_PIN4);
  wire       g3_ov  = segment_driver_enable &
                      (segment_port_mask > PFGM_MASK_PIN3);
  wire       g2_ov  = segment_driver_enable;
  wire       g10_ov = segment_driver_enable &
                      (segment_port_mask > PFGM_MASK_PIN10);
  // Upper F pins all follow the scan enable, lower F pins never override
  wire [7:0] f_en   = {{4{scan_port_enable_i}}, 4'h0};
  wire [7:0] f_dov  = {1'b0, shifting, 6'h00};
  wire [7:0] f_port_value_override_enable = {1'b0, scan_port_enable_i, 6'h00};
  wire [7:0] f_port_value_override_value = {1'b0, scan_data_out_i, 6'h00};
  wire [4:0] g_en   = {g4_ov, g3_ov, g2_ov, g10_ov, g10_ov};
  wire [4:0] g_dov  = 5'h10;
  wire [7:0] f_pu, f_dir, f_val, f_die;
  wire [4:0] g_pu, g_dir, g_val, g_die;

  // Port F: upper four pins get pull-up forced 1, input forced 0 under scan
  genvar i;
  generate
    for (i = 0; i < 8; i++) begin : g_f
      pfgm_pin_sel u_sel (
        .pu_reg_i  (port_f_pu_i[i]),
        .dir_reg_i (port_f_dir_i[i]),
        .val_reg_i (port_f_reg_i[i]),
        .pu_oe_i   (f_en[i]),
        .pu_ov_i   (1'b1),
        .dir_oe_i  (f_en[i]),
        .dir_ov_i  (f_dov[i]),
        .val_oe_i  (f_port_value_override_enable[i]),
        .val_ov_i  (f_port_value_override_value[i]),
        .die_oe_i  (f_en[i]),
        .die_ov_i  (1'b0),
        .pu_o      (f_pu[i]),
        .dir_o     (f_dir[i]),
        .val_o     (f_val[i]),
        .die_o     (f_die[i])
      );
    end
    // Port G: LCD takes pins, pull-up and input forced off
    for (i = 0; i < 5; i++) begin : g_g
      pfgm_pin_sel u_sel (
        .pu_reg_i  (port_g_pu_i[i]),
        .dir_reg_i (port_g_dir_i[i]),
        .val_reg_i (port_g_reg_i[i]),
        .pu_oe_i   (g_en[i]),
        .pu_ov_i   (1'b0),
        .dir_oe_i  (g_en[i]),
        .dir_ov_i  (g_dov[i]),
        .val_oe_i  (1'b0),
        .val_ov_i  (1'b0),
        .die_oe_i  (g_en[i]),
        .die_ov_i  (1'b0),
        .pu_o      (g_pu[i]),
        .dir_o     (g_dir[i]),
        .val_o     (g_val[i]),
        .die_o     (g_die[i])
      );
    end
  endgenerate

  // All pad controls registered so outputs come from flops
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      port_a_out_o          <= PFGM_RST_PORT_A;
      port_a_oe_o           <= PFGM_RST_PORT_A;
      port_f_pu_o           <= 8'h00;
      port_f_oe_o           <= 8'h00;
      port_f_out_o          <= 8'h00;
      port_f_die_o          <= 8'h00;
      port_f_analog_o       <= 8'h00;
      port_g_pu_o           <= 5'h00;
      port_g_oe_o           <= 5'h00;
      port_g_out_o          <= 5'h00;
      port_g_die_o          <= 5'h00;
      port_g4_toggle_oe_o   <= 1'b1;
      timer_zero_clock_in_o <= 1'b0;
      timer_one_clock_in_o  <= 1'b0;
      lcd_front_plane_o     <= 5'h00;
    end else begin
      port_a_out_o          <= port_a_output_data_ff;
      port_a_oe_o           <= port_a_direction_ff;
      port_f_pu_o           <= f_pu;
      port_f_oe_o           <= f_dir;
      port_f_out_o          <= f_val;
      port_f_die_o          <= f_die;
      port_f_analog_o       <= 8'hff;  // every F pin feeds converter/scan
      port_g_pu_o           <= g_pu;
      port_g_oe_o           <= g_dir;
      port_g_out_o          <= g_val;
      port_g_die_o          <= g_die;
      port_g4_toggle_oe_o   <= 1'b1;
      // Timer clocks only see the pin while its input is enabled
      timer_zero_clock_in_o <= g_pin_s2_ff[4] & g_die[4];
      timer_one_clock_in_o  <= g_pin_s2_ff[3] & g_die[3];
      // Analog side: bit4 plane 23, bit3 plane 24, 2 plane 4, 1/0 13/14
      lcd_front_plane_o     <= g_en;
    end
  end

  chk_scan_dir_out: assert property (@(posedge ref_clk_i)
    disable iff (sys_rst_i) scan_port_enable_i |=>
      port_f_oe_o[7:4] == {1'b0, $past(shifting), 2'b00})
    else $error("scan direction wrong");
  chk_scan_pullup: assert property (@(posedge ref_clk_i)
    disable iff (sys_rst_i) scan_port_enable_i |=> &port_f_pu_o[7:4])
    else $error("scan pull-up not forced");
  chk_scan_tdo: assert property (@(posedge ref_clk_i)
    disable iff (sys_rst_i) scan_port_enable_i |=>
      port_f_out_o[6] == $past(scan_data_out_i))
    else $error("data-out not from scan");
  chk_scan_die: assert property (@(posedge ref_clk_i)
    disable iff (sys_rst_i) scan_port_enable_i |=> port_f_die_o[7:4] == 4'h0)
    else $error("scan input not disabled");
  chk_low_f_free: assert property (@(posedge ref_clk_i)
    disable iff (sys_rst_i) !sys_rst_i |=>
      port_f_oe_o[3:0] == $past(port_f_dir_i[3:0]) && &port_f_die_o[3:0])
    else $error("lower F overridden");
  chk_g4_lcd: assert property (@(posedge ref_clk_i)
    disable iff (sys_rst_i) (!sys_rst_i && lcd_en_ff && port_mask_ff > 3'h5) |=>
      port_g_oe_o[4] && !port_g_pu_o[4] && !port_g_die_o[4])
    else $error("pin 4 LCD override wrong");
  chk_g3_lcd: assert property (@(posedge ref_clk_i)
    disable iff (sys_rst_i) (lcd_en_ff && port_mask_ff > 3'h6) |=>
      !port_g_oe_o[3] && !port_g_die_o[3] && !timer_one_clock_in_o)
    else $error("pin 3 LCD override wrong");
  chk_g2_lcd: assert property (@(posedge ref_clk_i)
    disable iff (sys_rst_i) (!sys_rst_i && lcd_en_ff) |=>
      !port_g_die_o[2] && lcd_front_plane_o[2])
    else $error("pin 2 not taken");
  chk_g10_lcd: assert property (@(posedge ref_clk_i)
    disable iff (sys_rst_i) (lcd_en_ff && port_mask_ff != 3'h0) |=>
      port_g_die_o[1:0] == 2'b00 && port_g_oe_o[1:0] == 2'b00)
    else $error("pins 1/0 not taken");
  chk_toggle_one: assert property (@(posedge ref_clk_i)
    disable iff (sys_rst_i) port_g4_toggle_oe_o)
    else $error("toggle override low");
  chk_reg_write: assert property (@(posedge ref_clk_i)
    disable iff (sys_rst_i) (wr && hit_d) |=> ##1
      port_a_out_o == $past(pwdata_i[7:0], 2))
    else $error("port A write lost");
  chk_plane23: assert property (@(posedge ref_clk_i)
    disable iff (sys_rst_i) !sys_rst_i |=>
      lcd_front_plane_o[4] == $past(g4_ov))
    else $error("plane 23 mismatch");
  // Remaining front planes follow their own override terms
  chk_plane_low: assert property (@(posedge ref_clk_i)
    disable iff (sys_rst_i) !sys_rst_i |=>
      lcd_front_plane_o[3] == $past(g3_ov) &&
      lcd_front_plane_o[2] == $past(g2_ov) &&
      lcd_front_plane_o[1:0] == {2{$past(g10_ov)}})
    else $error("front plane mismatch");
  // Lower F pins pass pull-up and value straight through
  chk_low_f_pu: assert property (@(posedge ref_clk_i)
    disable iff (sys_rst_i) !sys_rst_i |=>
      port_f_pu_o[3:0] == $past(port_f_pu_i[3:0]) &&
      port_f_out_o[3:0] == $past(port_f_reg_i[3:0]))
    else $error("lower F pull-up or value overridden");
  // Without scan the upper F pins are ordinary port pins
  chk_f_free: assert property (@(posedge ref_clk_i)
    disable iff (sys_rst_i) (!sys_rst_i && !scan_port_enable_i) |=>
      port_f_oe_o[7:4] == $past(port_f_dir_i[7:4]) &&
      port_f_pu_o[7:4] == $past(port_f_pu_i[7:4]) &&
      port_f_out_o[7:4] == $past(port_f_reg_i[7:4]) &&
      &port_f_die_o[7:4])
    else $error("upper F overridden without scan");
  // With the segment driver off, port G is untouched
  chk_g_free: assert property (@(posedge ref_clk_i)
    disable iff (sys_rst_i) (!sys_rst_i && !lcd_en_ff) |=>
      port_g_oe_o == $past(port_g_dir_i) &&
      port_g_pu_o == $past(port_g_pu_i) && &port_g_die_o)
    else $error("port G overridden with LCD off");
  // No G pin has a value override, so the register bit always drives
  chk_g_value: assert property (@(posedge ref_clk_i)
    disable iff (sys_rst_i) !sys_rst_i |=>
      port_g_out_o == $past(port_g_reg_i))
    else $error("port G value overridden");
  // Timer clocks see the synchronised pin only while the LCD leaves it
  chk_timer_zero: assert property (@(posedge ref_clk_i)
    disable iff (sys_rst_i) !sys_rst_i |=>
      timer_zero_clock_in_o == ($past(g_pin_s2_ff[4]) && !$past(g4_ov)))
    else $error("timer zero clock wrong");
  chk_timer_one: assert property (@(posedge ref_clk_i)
    disable iff (sys_rst_i) !sys_rst_i |=>
      timer_one_clock_in_o == ($past(g_pin_s2_ff[3]) && !$past(g3_ov)))
    else $error("timer one clock wrong");
  // Converter and scan analog path stays connected on every F pin
  chk_analog_on: assert property (@(posedge ref_clk_i)
    disable iff (sys_rst_i) !sys_rst_i |=> port_f_analog_o == 8'hff)
    else $error("analog path cut");
  // Read data is captured at the setup edge and stands in the access phase
  chk_read_data: assert property (@(posedge ref_clk_i)
    disable iff (sys_rst_i) (psel_i && !penable_i && hit_d) |=>
      prdata_o == {24'h000000, $past(port_a_output_data_ff)})
    else $error("port A read data wrong");
  chk_unmapped_err: assert property (@(posedge ref_clk_i)
    disable iff (sys_rst_i) (psel_i && !penable_i && !hit) |=> pslverr_o)
    else $error("unmapped access without error");
  // Direction write: access edge, register, then pad copy
  sequence s_dir_write;
    wr && hit_r;
  endsequence
  chk_dir_write: assert property (@(posedge ref_clk_i)
    disable iff (sys_rst_i) s_dir_write |=> ##1
      port_a_oe_o == $past(pwdata_i[7:0], 2))
    else $error("port A direction write lost");
endmodule

/* tb/pfgm_pad_model.sv */
`timescale 1ns/1ns
// Port G pad ring: a pin the device drives shows its own value, otherwise
// the board drives it; a released pin with no pull-up drifts, shown as the
// inverse of its last level so a stale value never passes by luck
module pfgm_pad_model (
  input  wire logic       ref_clk_i,
  input  wire logic [4:0] oe_i,
  input  wire logic [4:0] out_i,
  input  wire logic [4:0] pu_i,
  input  wire logic [4:0] ext_en_i,
  input  wire logic [4:0] ext_val_i,
  output logic      [4:0] pin_o
);
  logic [4:0] last_ff = 5'h00;

  // Last pad level, used only for a floating pin
  always_ff @(posedge ref_clk_i) begin
    last_ff <= pin_o;
  end

  // Resolve each pad from device, board and pull-up
  always_comb begin
    for (int i = 0; i < 5; i++) begin
      if (oe_i[i])
        pin_o[i] = out_i[i];
      else if (ext_en_i[i])
        pin_o[i] = ext_val_i[i];
      else if (pu_i[i])
        pin_o[i] = 1'b1;
      else
        pin_o[i] = ~last_ff[i];
    end
  end
endmodule

/* tb/port_f_g_override_mux_tb.sv */
`timescale 1ns/1ns
`define CHK(got, exp) begin \
  compares++; \
  if ((got) !== (exp)) begin \
    err_count++; \
    $display("wrong value at %0t: got %h want %h", $time, got, exp); \
  end \
end
module port_f_g_override_mux_tb;
  import pfgm_pkg::*;
  typedef struct packed {
    logic [3:0] sc;
    logic       lcd;
    logic [2:0] m;
    logic [4:0] ov;
    logic [3:0] foe;
  } pfgm_row_s;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        psel, penable, pwrite, pready, pslverr, err_flag;
  logic        scan, ir, dr, tdo, tog, t0, t1;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [7:0]  f_reg, f_dir, f_pu, a_out, a_oe;
  logic [7:0]  f_pu_o, f_oe, f_out, f_die, f_an;
  logic [4:0]  g_reg, g_dir, g_pu, g_pin, ext_en, ext_val;
  logic [4:0]  g_pu_o, g_oe, g_out, g_die, fp;
  int          err_count = 0;
  int          compares = 0;
  pfgm_row_s   rows [7];
  pfgm_row_s   r;

  // Free running clock, 40 ns period
  always #20 clk = ~clk;

  pfgm_top pfgm_top_i (.ref_clk_i(clk), .sys_rst_i(rst), .psel_i(psel),
    .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr),
    .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
    .pslverr_o(pslverr), .scan_port_enable_i(scan),
    .tap_shifting_instruction_i(ir), .tap_shifting_data_i(dr),
    .scan_data_out_i(tdo), .port_f_reg_i(f_reg), .port_f_dir_i(f_dir),
    .port_f_pu_i(f_pu), .port_g_reg_i(g_reg), .port_g_dir_i(g_dir),
    .port_g_pu_i(g_pu), .port_g_pin_i(g_pin), .port_a_out_o(a_out),
    .port_a_oe_o(a_oe), .port_f_pu_o(f_pu_o), .port_f_oe_o(f_oe),
    .port_f_out_o(f_out), .port_f_die_o(f_die), .port_f_analog_o(f_an),
    .port_g_pu_o(g_pu_o), .port_g_oe_o(g_oe), .port_g_out_o(g_out),
    .port_g_die_o(g_die), .port_g4_toggle_oe_o(tog),
    .timer_zero_clock_in_o(t0), .timer_one_clock_in_o(t1),
    .lcd_front_plane_o(fp));

  pfgm_pad_model pfgm_pad_model_i (.ref_clk_i(clk), .oe_i(g_oe),
    .out_i(g_out), .pu_i(g_pu_o), .ext_en_i(ext_en), .ext_val_i(ext_val),
    .pin_o(g_pin));

  // One APB transfer; request held until pready is seen at an edge
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    err_flag = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Three-cycle reset, then the reset state of the outputs
  task do_reset;
    rst <= 1'b1;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    @(negedge clk);
    `CHK(a_out, 8'h00)
    `CHK(a_oe, 8'h00)
    `CHK(tog, 1'b1)
    `CHK(pready, 1'b1)
    `CHK(fp, 5'h00)
    $display("test reset done");
  endtask

  task summarize;
    $display("compares %0d err_count %0d", compares, err_count);
    if (err_count == 0 && compares > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // Rows go 8 cycles each; a hang far beyond that is cut short
  initial begin
    repeat (3000) @(posedge clk);
    err_count++;
    summarize;
  end

  // Main sequence: table of override cases, then registers and reset
  initial begin
    {psel, penable, pwrite, scan, ir, dr, tdo} = '0;
    paddr = '0;
    pwdata = '0;
    f_reg = 8'ha5;
    f_dir = 8'h3c;
    f_pu = 8'h0f;
    g_reg = 5'h15;
    g_dir = 5'h03;
    g_pu = 5'h1b;
    ext_en = 5'h1f;
    ext_val = 5'h18;
    // Mask boundaries 0, 5 and 6, both shift states, data-out alone
    rows = '{'{4'h0, 1'h0, 3'h0, 5'h00, 4'h3},
             '{4'h9, 1'h1, 3'h0, 5'h04, 4'h0},
             '{4'hc, 1'h1, 3'h1, 5'h07, 4'h4},
             '{4'hb, 1'h1, 3'h5, 5'h07, 4'h4},
             '{4'h0, 1'h1, 3'h6, 5'h17, 4'h3},
             '{4'h0, 1'h1, 3'h7, 5'h1f, 4'h3},
             '{4'h1, 1'h0, 3'h7, 5'h00, 4'h3}};
    do_reset;
    foreach (rows[i]) begin
      r = rows[i];
      @(posedge clk);
      {scan, ir, dr, tdo} <= r.sc;
      apb(1'b1, PFGM_OFS_SEG_CTRL, {28'h0, r.m, r.lcd});
      // Pin to timer clock path needs four cycles to settle
      repeat (4) @(posedge clk);
      @(negedge clk);
      `CHK(fp, r.ov)
      `CHK(f_oe, {r.foe, f_dir[3:0]})
      `CHK(f_pu_o, r.sc[3] ? {4'hf, f_pu[3:0]} : f_pu)
      `CHK(f_die, r.sc[3] ? 8'h0f : 8'hff)
      `CHK(f_out, r.sc[3] ? {f_reg[7],r.sc[0],f_reg[5:0]} : f_reg)
      `CHK(f_an, 8'hff)
      `CHK(g_oe, (g_dir & ~r.ov) | {r.ov[4], 4'h0})
      `CHK(g_die, ~r.ov)
      `CHK(g_pu_o, g_pu & ~r.ov)
      `CHK(g_out, g_reg)
      `CHK(t0, ~r.ov[4])
      `CHK(t1, ~r.ov[3])
      $display("test row %0d done", i);
    end
    apb(1'b1, PFGM_OFS_PORT_A_DATA, 32'hffff_ffa5);
    apb(1'b0, PFGM_OFS_PORT_A_DATA, 32'h0);
    `CHK(rd, 32'h0000_00a5)
    `CHK(a_out, 8'ha5)
    apb(1'b1, PFGM_OFS_PORT_A_DIR, 32'h0000_005a);
    apb(1'b0, PFGM_OFS_PORT_A_DIR, 32'h0);
    `CHK(rd, 32'h0000_005a)
    `CHK(a_oe, 8'h5a)
    apb(1'b0, 12'h010, 32'h0);
    `CHK(rd, 32'h0)
    `CHK(err_flag, 1'b1)
    // Control readback holds the last row: mask 7, LCD off
    apb(1'b0, PFGM_OFS_SEG_CTRL, 32'h0);
    `CHK(rd, 32'h0000_000e)
    `CHK(err_flag, 1'b0)
    // Pins 1/0 driven from the register, 4..2 from the board
    apb(1'b0, PFGM_OFS_PIN_STATUS, 32'h0);
    `CHK(rd, 32'h0000_0019)
    $display("test registers done");
    // Board pulls the timer pins low: the clocks must follow the pin
    @(posedge clk);
    ext_val <= 5'h00;
    repeat (4) @(posedge clk);
    @(negedge clk);
    `CHK(t0, 1'b0)
    `CHK(t1, 1'b0)
    apb(1'b0, PFGM_OFS_PIN_STATUS, 32'h0);
    `CHK(rd, 32'h0000_0001)
    $display("test pin inputs done");
    do_reset;
    apb(1'b0, PFGM_OFS_PORT_A_DATA, 32'h0);
    `CHK(rd, 32'h0)
    summarize;
  end
endmodule
